// ===== inc/nfbc_pkg.sv
package nfbc_pkg;
	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [31:0] BUS_CTRL_ADDR = 32'hfffc0004;
	localparam logic [31:0] WAIT_CTRL_ADDR = 32'hfffc0028;
	localparam logic [31:0] PIN_CTRL_ADDR = 32'hfffc0100;
	localparam logic [31:0] STATUS_ADDR = 32'hfffc0104;

	// ****************************************
	// Bus control fields
	// ****************************************
	localparam int IDLE_AFTER_WRITE_LSB = 28;
	localparam int IDLE_READ_WRITE_DIFF_LSB = 24;
	localparam int IDLE_READ_WRITE_SAME_LSB = 21;
	localparam int IDLE_READ_READ_DIFF_LSB = 18;
	localparam int IDLE_READ_READ_SAME_LSB = 15;
	localparam int MEM_TYPE_LSB = 12;
	localparam int BYTE_ORDER_BIT = 11;
	localparam int BUS_SIZE_LSB = 9;
	localparam logic [31:0] BUS_CTRL_MASK = 32'h7ffff800;
	localparam logic [31:0] BUS_CTRL_RESET = 32'h00000000;
	localparam logic [2:0] MEM_TYPE_NORMAL = 3'h0;
	localparam logic [1:0] BUS_SIZE_16 = 2'h2;
	localparam logic [1:0] BUS_SIZE_8 = 2'h1;

	// ****************************************
	// Wait control fields
	// ****************************************
	localparam int SETUP_DELAY_LSB = 11;
	localparam int WAIT_COUNT_LSB = 7;
	localparam int WAIT_MASK_BIT = 6;
	localparam int HOLD_DELAY_LSB = 0;
	localparam logic [31:0] WAIT_CTRL_MASK = 32'h00001fc3;
	localparam logic [31:0] WAIT_CTRL_RESET = 32'h00001f83;

	// ****************************************
	// Pin control and status fields
	// ****************************************
	localparam int PIN_SELECT_BIT = 0;
	localparam int PORT_DATA_LSB = 8;
	localparam int PORT_DIR_LSB = 16;
	localparam int PORT_IN_LSB = 24;
	localparam logic [31:0] PIN_CTRL_MASK = 32'h003f3f01;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NARROW_BIT = 1;

	// ****************************************
	// Bus answers and timing
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// One clock is half a bus cycle, so 1.5 bus cycles is three clocks
	localparam int HALVES_PER_BUS_CYCLE = 2;

	function automatic logic bus_size_is_16(input logic [1:0] code);
		return code == BUS_SIZE_16;
	endfunction
endpackage

// ===== design/nfbc_seq.sv
`timescale 1ns/1ns
`default_nettype none
module nfbc_seq
	import nfbc_pkg::*;
#(
	parameter int CNT_W = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [2:0] idle_cycles,
	input wire logic [1:0] setup_sel,
	input wire logic [3:0] wait_sel,
	input wire logic [1:0] hold_sel,
	input wire logic wait_mask,
	input wire logic ext_wait_n,
	output logic busy,
	output logic cs_on,
	output logic strobe_on,
	output logic sample,
	output logic finish
);
	typedef enum logic [2:0] {S_IDLE, S_GAP, S_SETUP, S_T1, S_WAIT, S_T2, S_HOLD} nfbc_state_e;

	nfbc_state_e state;
	logic [CNT_W-1:0] cnt;

	if (CNT_W < 5) begin : g_chk
		$error("CNT_W too small for the longest wait");
	end

	// Half-cycle count minus one, for 0.5/1.5/2.5/3.5 cycle spans
	function automatic logic [CNT_W-1:0] half_span(input logic [1:0] sel);
		return CNT_W'({sel, 1'b0});
	endfunction

	function automatic logic [CNT_W-1:0] whole_span(input logic [3:0] n);
		return CNT_W'(n * HALVES_PER_BUS_CYCLE) - CNT_W'(1);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			cnt <= '0;
		end else begin
			unique case (state)
				S_IDLE: if (start) begin
					// Gap belongs to the space between accesses, never inside one
					if (idle_cycles != 3'h0) begin // RULE_18
						state <= S_GAP; // RULE_05
						cnt <= whole_span({1'b0, idle_cycles});
					end else begin
						state <= S_SETUP; // RULE_06
						cnt <= half_span(setup_sel);
					end
				end
				S_GAP: if (cnt == '0) begin
					state <= S_SETUP;
					cnt <= half_span(setup_sel); // RULE_09
				end else cnt <= cnt - CNT_W'(1);
				S_SETUP: if (cnt == '0) begin
					state <= S_T1; // RULE_19
					cnt <= CNT_W'(1);
				end else cnt <= cnt - CNT_W'(1);
				S_T1: if (cnt == '0) begin
					if (wait_sel != 4'h0) begin
						state <= S_WAIT; // RULE_17
						cnt <= whole_span(wait_sel); // RULE_10
					end else begin
						state <= S_T2;
						cnt <= CNT_W'(1);
					end
				end else cnt <= cnt - CNT_W'(1);
				S_WAIT: if (cnt != '0) begin
					cnt <= cnt - CNT_W'(1);
				end else if (wait_mask || ext_wait_n) begin // RULE_11
					state <= S_T2;
					cnt <= CNT_W'(1);
				end
				S_T2: if (cnt == '0) begin
					state <= S_HOLD;
					cnt <= half_span(hold_sel); // RULE_12
				end else cnt <= cnt - CNT_W'(1);
				S_HOLD: if (cnt == '0) begin
					state <= S_IDLE;
				end else cnt <= cnt - CNT_W'(1);
			endcase
		end
	end

	assign busy = state != S_IDLE;
	assign cs_on = state inside {S_SETUP, S_T1, S_WAIT, S_T2, S_HOLD};
	assign strobe_on = state inside {S_T1, S_WAIT, S_T2};
	assign sample = state == S_T2 && cnt == '0;
	assign finish = state == S_HOLD && cnt == '0;
endmodule
`default_nettype wire

// ===== design/nfbc_top.sv
// Notes on behaviour
// RULE_01: Strap low gives a 16-bit bus, strap high an 8-bit bus.
// RULE_02: Strap level is caught once after reset and then held.
// RULE_03: Software writes to the bus-size field are dropped; strap decides width.
// RULE_04: Bus-size code binary 10 means a 16-bit bus.
// RULE_05: Write-following idle field gives idle cycles after a write; 001 gives one.
// RULE_06: Read-following idle fields at 000 insert no idle cycles.
// RULE_07: Memory type 000 marks the region as normal static space.
// RULE_08: Byte-order bit 0 places bytes big-endian on the bus.
// RULE_09: Set-up field delays the strobe after chip select; 01 gives 1.5 cycles.
// RULE_10: Four-bit wait field gives access-wait cycles; 0101 gives five.
// RULE_11: Wait-mask bit set makes the external wait input ignored.
// RULE_12: Hold field keeps address and select after strobe; 01 gives 1.5 cycles.
// RULE_13: Memory type and bus width are kept per region.
// RULE_14: Upper address pins stay port pins until pin selection switches them.
// RULE_15: Low-byte write strobe marks a write on the low data lane.
// RULE_16: Read strobe is the output enable for data from memory.
// RULE_17: Access-wait cycles sit between the first and second basic cycles.
// RULE_18: Idle cycles go between accesses, never inside one.
// RULE_19: Access order: select, set-up, strobe, waits, strobe off, hold.
`timescale 1ns/1ns
`default_nettype none
module nfbc_top
	import nfbc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_half,
	input wire logic [22:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [15:0] rsp_rdata,
	input wire logic width_strap_pin,
	output logic region0_chip_select_n,
	output logic read_strobe_n,
	output logic low_byte_write_strobe_n,
	output logic high_byte_write_strobe_n,
	input wire logic ext_wait_n,
	output logic [16:0] addr_out,
	input wire logic [5:0] upper_pin_in,
	output logic [5:0] upper_pin_out,
	output logic [5:0] upper_pin_oe,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe
);
	// ****************************************
	// Register state
	// ****************************************
	logic [31:0] bus_ctrl, wait_ctrl, pin_ctrl, aw_addr, w_data;
	logic [3:0] w_strb;
	logic strap_taken, strap_narrow, aw_held, w_held;
	logic [1:0] eff_bus_size;
	logic bus16, little, pin_select;

	// ****************************************
	// Access state
	// ****************************************
	logic acc_write, acc_half, acc_hi, had_prev, last_write;
	logic [2:0] next_idle;
	logic accept, refuse;
	logic seq_busy, cs_on, strobe_on, sample, finish;

	function automatic logic [15:0] swap16(input logic [15:0] v);
		return {v[7:0], v[15:8]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
			input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
		return r & mask;
	endfunction

	// ****************************************
	// Strap capture
	// ****************************************
	// Caught by a clocked process after release, never loaded under reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_taken <= 1'b0;
			strap_narrow <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1; // RULE_02
			strap_narrow <= width_strap_pin; // RULE_01
		end
	end

	assign eff_bus_size = strap_narrow ? BUS_SIZE_8 : BUS_SIZE_16; // RULE_01
	assign bus16 = bus_size_is_16(eff_bus_size); // RULE_04
	assign little = bus_ctrl[BYTE_ORDER_BIT]; // RULE_08
	assign pin_select = pin_ctrl[PIN_SELECT_BIT];

	// ****************************************
	// Register write channel
	// ****************************************
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (aw_held && w_held) begin
			w_held <= 1'b0;
		end
	end

	// Bus-size bits are outside the write mask, so writes never reach them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_ctrl <= BUS_CTRL_RESET;
			wait_ctrl <= WAIT_CTRL_RESET;
			pin_ctrl <= '0; // RULE_14
		end else if (aw_held && w_held) begin
			unique case (aw_addr)
				BUS_CTRL_ADDR: bus_ctrl <= merge(bus_ctrl, w_data, w_strb, BUS_CTRL_MASK); // RULE_03
				WAIT_CTRL_ADDR: wait_ctrl <= merge(wait_ctrl, w_data, w_strb, WAIT_CTRL_MASK);
				PIN_CTRL_ADDR: pin_ctrl <= merge(pin_ctrl, w_data, w_strb, PIN_CTRL_MASK);
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr inside {BUS_CTRL_ADDR, WAIT_CTRL_ADDR, PIN_CTRL_ADDR})
				? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Register read channel
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				// Width field reads back what the strap chose
				BUS_CTRL_ADDR: s_axi_rdata <= bus_ctrl | {21'h0, eff_bus_size, 9'h0}; // RULE_13
				WAIT_CTRL_ADDR: s_axi_rdata <= wait_ctrl;
				PIN_CTRL_ADDR: s_axi_rdata <= pin_ctrl | {2'h0, upper_pin_in, 24'h0};
				STATUS_ADDR: s_axi_rdata <= {30'h0, strap_narrow, seq_busy};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_DECERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Access requests
	// ****************************************
	// Half-word on an 8-bit bus or a non-normal space is answered with an error
	assign req_ready = strap_taken && !seq_busy && !rsp_valid;
	assign refuse = bus_ctrl[MEM_TYPE_LSB +: 3] != MEM_TYPE_NORMAL // RULE_07
		|| (req_half && !bus16);
	assign accept = req_valid && req_ready && !refuse;

	// One region only, so the same-space read idle fields apply
	always_comb begin
		next_idle = 3'h0;
		if (had_prev && last_write) begin
			next_idle = bus_ctrl[IDLE_AFTER_WRITE_LSB +: 3]; // RULE_05
		end else if (had_prev && req_write) begin
			next_idle = bus_ctrl[IDLE_READ_WRITE_SAME_LSB +: 3]; // RULE_06
		end else if (had_prev) begin
			next_idle = bus_ctrl[IDLE_READ_READ_SAME_LSB +: 3]; // RULE_06
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_write <= 1'b0;
			acc_half <= 1'b0;
			acc_hi <= 1'b0;
			had_prev <= 1'b0;
			last_write <= 1'b0;
			addr_out <= '0;
			data_out <= '0;
		end else if (accept) begin
			acc_write <= req_write;
			acc_half <= req_half;
			// Big-endian puts the even byte on the high lane
			acc_hi <= bus16 && (req_addr[0] == little); // RULE_08
			had_prev <= 1'b1;
			last_write <= req_write;
			addr_out <= req_addr[16:0];
			if (req_half) begin
				data_out <= little ? swap16(req_wdata) : req_wdata; // RULE_08
			end else begin
				data_out <= {req_wdata[7:0], req_wdata[7:0]};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid <= 1'b0;
			rsp_err <= 1'b0;
			rsp_rdata <= '0;
		end else if (req_valid && req_ready && refuse) begin
			rsp_valid <= 1'b1;
			rsp_err <= 1'b1;
		end else if (finish) begin
			rsp_valid <= 1'b1;
			rsp_err <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (sample && !acc_write) begin // RULE_16
				if (acc_half) begin
					rsp_rdata <= little ? swap16(data_in) : data_in;
				end else begin
					rsp_rdata <= {8'h0, acc_hi ? data_in[15:8] : data_in[7:0]};
				end
			end
		end
	end

	// ****************************************
	// Access sequencer
	// ****************************************
	nfbc_seq #(
		.CNT_W(5)
	) u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(accept),
		.idle_cycles(next_idle),
		.setup_sel(wait_ctrl[SETUP_DELAY_LSB +: 2]),
		.wait_sel(wait_ctrl[WAIT_COUNT_LSB +: 4]),
		.hold_sel(wait_ctrl[HOLD_DELAY_LSB +: 2]),
		.wait_mask(wait_ctrl[WAIT_MASK_BIT]),
		.ext_wait_n(ext_wait_n),
		.busy(seq_busy),
		.cs_on(cs_on),
		.strobe_on(strobe_on),
		.sample(sample),
		.finish(finish)
	);

	// ****************************************
	// Pins
	// ****************************************
	// Registered so strobes and select never glitch between states
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			region0_chip_select_n <= 1'b1;
			read_strobe_n <= 1'b1;
			low_byte_write_strobe_n <= 1'b1;
			high_byte_write_strobe_n <= 1'b1;
			data_oe <= 1'b0;
		end else begin
			region0_chip_select_n <= !cs_on; // RULE_19
			read_strobe_n <= !(strobe_on && !acc_write); // RULE_16
			low_byte_write_strobe_n <= !(strobe_on && acc_write && (acc_half || !acc_hi)); // RULE_15
			high_byte_write_strobe_n <= !(strobe_on && acc_write && (acc_half || acc_hi));
			data_oe <= cs_on && acc_write;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_pin_out <= '0;
			upper_pin_oe <= '0;
		end else if (pin_select) begin
			if (accept) upper_pin_out <= req_addr[22:17];
			upper_pin_oe <= 6'h3f;
		end else begin
			upper_pin_out <= pin_ctrl[PORT_DATA_LSB +: 6]; // RULE_14
			upper_pin_oe <= pin_ctrl[PORT_DIR_LSB +: 6];
		end
	end
endmodule
`default_nettype wire

// ===== design/nfbc_top_fix.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== testbench/nfbc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module nfbc_asserts
	import nfbc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic region0_chip_select_n,
	input wire logic read_strobe_n,
	input wire logic low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic data_oe,
	input wire logic [5:0] upper_pin_oe
);
	// ********
	// Shadow state
	// ********
	logic [31:0] wctl;
	logic [6:0] cnt;
	logic cs_q;
	logic stb_q;
	wire logic stb_n = read_strobe_n & low_byte_write_strobe_n & high_byte_write_strobe_n;
	wire logic aw_hit = s_axi_awvalid && s_axi_awready && s_axi_awaddr == WAIT_CTRL_ADDR;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wctl <= WAIT_CTRL_RESET;
		end else if (aw_hit && s_axi_wvalid && s_axi_wready) begin
			wctl <= s_axi_wdata & WAIT_CTRL_MASK;
		end
	end
	// Sampled at a pin change, cnt is the length of the phase that just ended
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 7'h0;
			cs_q <= 1'b1;
			stb_q <= 1'b1;
		end else begin
			cs_q <= region0_chip_select_n;
			stb_q <= stb_n;
			cnt <= (cs_q != region0_chip_select_n || stb_q != stb_n) ? 7'h1 : cnt + 7'h1;
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_setup_delay: assert property ($fell(stb_n) |-> cnt == {wctl[12:11], 1'b1})
		else $error("strobe set-up length wrong");
	a_strobe_width: assert property ($rose(stb_n) && wctl[6] |->
			cnt == {wctl[10:7], 1'b0} + 7'h4)
		else $error("strobe width wrong");
	a_hold_delay: assert property ($rose(region0_chip_select_n) |->
			stb_n && cnt == {wctl[1:0], 1'b1})
		else $error("select hold length wrong");
	a_strobe_inside: assert property (!stb_n |-> !region0_chip_select_n)
		else $error("strobe outside select");
	a_read_released: assert property (!read_strobe_n |-> !data_oe)
		else $error("data driven during read");
	a_low_write_drives: assert property (!low_byte_write_strobe_n |-> data_oe)
		else $error("low write without data");
	a_refused_quiet: assert property (rsp_valid && rsp_err |->
			region0_chip_select_n && $stable(region0_chip_select_n))
		else $error("refused access moved select");
	a_port_reset: assert property ($rose(aresetn) |-> upper_pin_oe == 6'h0)
		else $error("upper pins driven after reset");
	c_read: cover property ($fell(read_strobe_n));
	c_write: cover property ($fell(low_byte_write_strobe_n));
	c_refused: cover property (rsp_valid && rsp_err);
endmodule
`default_nettype wire

// ===== testbench/nfbc_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module nfbc_flash_model (
	input wire logic aclk,
	input wire logic region0_chip_select_n,
	input wire logic read_strobe_n,
	input wire logic low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic [16:0] addr_out,
	input wire logic [15:0] data_out,
	input wire logic slow,
	output logic [15:0] data_in,
	output logic ext_wait_n
);
	// ********
	// Word array, 16-bit lanes
	// ********
	logic [15:0] mem [0:255];
	logic [15:0] last = 16'h0;
	logic [4:0] wcnt = 5'h0;
	wire logic [7:0] idx = addr_out[8:1];
	wire logic sel = region0_chip_select_n === 1'b0;
	wire logic rd_on = sel && read_strobe_n === 1'b0;
	// Off the strobe the bus shows the inverse of its last value, never a stale match
	assign data_in = rd_on ? mem[idx] : ~last;
	assign ext_wait_n = !(slow && sel && wcnt < 5'h14);
	always @(posedge aclk) begin
		if (rd_on) last <= mem[idx];
		if (!sel) wcnt <= 5'h0;
		else if (wcnt != 5'h1f) wcnt <= wcnt + 5'h1;
		if (sel && !low_byte_write_strobe_n) mem[idx][7:0] <= data_out[7:0];
		if (sel && !high_byte_write_strobe_n) mem[idx][15:8] <= data_out[15:8];
	end
endmodule
`default_nettype wire

// ===== testbench/nfbc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module nfbc_top_tb
	import nfbc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid = 1'b0;
	logic req_write = 1'b0, req_half = 1'b0, width_strap_pin = 1'b0, slow = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [22:0] req_addr = 23'h0;
	logic [15:0] req_wdata = 16'h0;
	logic [5:0] upper_pin_in = 6'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic req_ready, rsp_valid, rsp_err, region0_chip_select_n, read_strobe_n;
	wire logic low_byte_write_strobe_n, high_byte_write_strobe_n, ext_wait_n, data_oe;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [15:0] rsp_rdata, data_in, data_out;
	wire logic [16:0] addr_out;
	wire logic [5:0] upper_pin_out, upper_pin_oe;
	int miscompares = 0, total_checks = 0, lat;
	logic gerr, lo_seen, hi_seen;
	logic [15:0] got;
	nfbc_top DUT (.*);
	nfbc_flash_model flash (.*);
	always #5 aclk = ~aclk;
	// Cleared at the accepting edge so only the current access is seen
	always @(posedge aclk) begin
		if (req_valid && req_ready) begin
			lo_seen <= 1'b0;
			hi_seen <= 1'b0;
		end else begin
			if (!low_byte_write_strobe_n) lo_seen <= 1'b1;
			if (!high_byte_write_strobe_n) hi_seen <= 1'b1;
		end
	end
	// ********
	// Bus tasks
	// ********
	task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 100);
		if (!s_axi_bvalid) miscompares++;
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask
	task automatic axr(input logic [31:0] a, e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 100);
		if (!s_axi_rvalid) miscompares++;
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
	endtask
	task automatic lacc(input logic w, h, input logic [22:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_half <= h;
		req_addr <= a;
		req_wdata <= d;
		do begin
			@(posedge aclk);
			n++;
		end while (!req_ready && n < 100);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(posedge aclk);
			lat++;
		end while (!rsp_valid && lat < 500);
		if (!rsp_valid) miscompares++;
		gerr = rsp_err;
		got = rsp_rdata;
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		axr(BUS_CTRL_ADDR, 32'h00000400, RESP_OKAY);
		axr(WAIT_CTRL_ADDR, WAIT_CTRL_RESET, RESP_OKAY);
		axr(32'hfffc0010, 32'h0, RESP_DECERR);
		`CHK(upper_pin_oe, 6'h00)
		$display("t_reset done");
	endtask
	task automatic t_config;
		axw(BUS_CTRL_ADDR, 32'h10000200, RESP_OKAY);
		axr(BUS_CTRL_ADDR, 32'h10000400, RESP_OKAY);
		axw(WAIT_CTRL_ADDR, 32'h00000ac1, RESP_OKAY);
		axr(WAIT_CTRL_ADDR, 32'h00000ac1, RESP_OKAY);
		axw(32'hfffc0008, 32'hffffffff, RESP_DECERR);
		axw(PIN_CTRL_ADDR, 32'h002a1500, RESP_OKAY);
		axr(PIN_CTRL_ADDR, 32'h002a1500, RESP_OKAY);
		`CHK(upper_pin_out, 6'h15)
		`CHK(upper_pin_oe, 6'h2a)
		axw(PIN_CTRL_ADDR, 32'h0, RESP_OKAY);
		width_strap_pin <= 1'b1;
		axr(STATUS_ADDR, 32'h0, RESP_OKAY);
		width_strap_pin <= 1'b0;
		$display("t_config done");
	endtask
	task automatic t_access;
		int l1;
		lacc(1'b1, 1'b1, 23'h10, 16'ha55a);
		`CHK(gerr, 1'b0)
		lacc(1'b1, 1'b0, 23'h11, 16'h003c);
		`CHK({lo_seen, hi_seen}, 2'b10)
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(got, 16'ha53c)
		l1 = lat;
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(got, 16'ha53c)
		`CHK(l1 - lat, 2)
		$display("t_access done");
	endtask
	task automatic t_wait;
		int l0;
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		l0 = lat;
		slow <= 1'b1;
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(lat, l0)
		axw(WAIT_CTRL_ADDR, 32'h00000a81, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(lat > l0, 1'b1)
		slow <= 1'b0;
		axw(WAIT_CTRL_ADDR, 32'h00000ac1, RESP_OKAY);
		$display("t_wait done");
	endtask
	task automatic t_type;
		axw(BUS_CTRL_ADDR, 32'h10001000, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(gerr, 1'b1)
		axw(BUS_CTRL_ADDR, 32'h10000000, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(gerr, 1'b0)
		lacc(1'b0, 1'b0, 23'h10, 16'h0);
		`CHK(got, 16'h00a5)
		axw(BUS_CTRL_ADDR, 32'h10000800, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(got, 16'h3ca5)
		lacc(1'b0, 1'b0, 23'h10, 16'h0);
		`CHK(got, 16'h003c)
		axw(BUS_CTRL_ADDR, 32'h10000000, RESP_OKAY);
		axw(PIN_CTRL_ADDR, 32'h00000001, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h540010, 16'h0);
		`CHK(got, 16'ha53c)
		`CHK({upper_pin_oe, upper_pin_out}, 12'hfea)
		axw(PIN_CTRL_ADDR, 32'h0, RESP_OKAY);
		$display("t_type done");
	endtask
	// Second reset with the strap high; the strap drops again once it has been taken
	task automatic t_strap8;
		width_strap_pin <= 1'b1;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		width_strap_pin <= 1'b0;
		axr(BUS_CTRL_ADDR, 32'h00000200, RESP_OKAY);
		axr(STATUS_ADDR, 32'h00000002, RESP_OKAY);
		lacc(1'b0, 1'b1, 23'h10, 16'h0);
		`CHK(gerr, 1'b1)
		lacc(1'b1, 1'b0, 23'h10, 16'h0077);
		`CHK({gerr, lo_seen, hi_seen}, 3'b010)
		$display("t_strap8 done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_config();
		t_access();
		t_wait();
		t_type();
		t_strap8();
		finish_test();
	end
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
endmodule
bind nfbc_top nfbc_asserts chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .rsp_valid, .rsp_err, .region0_chip_select_n,
	.read_strobe_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n, .data_oe, .upper_pin_oe);
`default_nettype wire
